// ### hw/cims_pkg.sv
// Package for the interrupt mask and status block of the processor core.
// Assumes a single processor clock and a synchronous active-high reset.
package cims_pkg;

  // Control word layout for the set-mask instruction
  localparam int unsigned CTRL_CLR_TOP_BIT = 4;
  localparam int unsigned CTRL_MSE_BIT = 3;
  localparam int unsigned CTRL_MASK_TOP_BIT = 2;
  localparam int unsigned CTRL_MASK_MID_BIT = 1;
  localparam int unsigned CTRL_MASK_BOT_BIT = 0;

  // Status word layout for the read-mask instruction
  localparam int unsigned STAT_PEND_TOP_BIT = 6;
  localparam int unsigned STAT_PEND_MID_BIT = 5;
  localparam int unsigned STAT_PEND_BOT_BIT = 4;
  localparam int unsigned STAT_GIE_BIT = 3;
  localparam int unsigned STAT_MASK_TOP_BIT = 2;
  localparam int unsigned STAT_MASK_MID_BIT = 1;
  localparam int unsigned STAT_MASK_BOT_BIT = 0;

  // Index of each vectored input inside three-bit vectors
  localparam int unsigned IRQ_TOP = 2;
  localparam int unsigned IRQ_MID = 1;
  localparam int unsigned IRQ_BOT = 0;
  localparam int unsigned IRQ_COUNT = 3;

  // Values after reset
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] REQUEST_RST = 3'h0;

  // Machine state of the current bus cycle
  typedef enum logic [2:0] {
    CIMS_T1 = 3'b000,
    CIMS_T2 = 3'b001,
    CIMS_T3 = 3'b010,
    CIMS_T4 = 3'b011,
    CIMS_T5 = 3'b100,
    CIMS_T6 = 3'b101,
    CIMS_TIDLE = 3'b110
  } cims_tstate_type;

endpackage : cims_pkg

// ### hw/cims_irq_cell.sv
// One vectored interrupt input: edge latch or level follower.
// Assumes the request pin is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cims_irq_cell #(
  parameter bit EDGE_MODE = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request pin and latch clear
  input wire logic irq_level,
  input wire logic clear_req,
  // Pending state
  output logic pending
);

  logic prev_ff;
  logic pend_ff;
  logic nxt_prev;
  logic nxt_pend;

  // Rising edge sets the latch and beats a clear in the same cycle
  always_comb begin
    nxt_prev = irq_level;
    if (EDGE_MODE) begin
      nxt_pend = (irq_level & ~prev_ff) | (pend_ff & ~clear_req);
    end else begin
      nxt_pend = irq_level;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      pend_ff <= nxt_pend;
    end
  end

  assign pending = pend_ff;

endmodule : cims_irq_cell
`default_nettype wire

// ### hw/cims_mask_status.sv
// Interrupt mask and status logic for three vectored restart inputs.
// Assumes instruction strobes come from the core's decoder, one cycle each,
// and that request pins are synchronous to sys_clk.
//
// Overview of operation
// R1 - Set-mask takes accumulator as control word
// R2 - Bit 4 clears top edge latch
// R3 - Mask bits apply only when bit 3 set
// R4 - Bit 2 masks top input
// R5 - Bit 1 masks middle input
// R6 - Bit 0 masks bottom input
// R7 - Read-mask loads status word into accumulator
// R8 - Status bits 6..4 show pending inputs
// R9 - Status bit 3 shows global enable
// R10 - Status bits 2..0 show mask bits
// R11 - Bus holds T3 value during T4..T6
// R12 - Without update enable masks stay; 7..5 ignored
// R13 - Masked inputs pend but are not serviced
`timescale 1ns/1ps
`default_nettype none
module cims_mask_status #(
  parameter int unsigned AD_WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Instruction strobes and accumulator
  input wire logic set_mask_instruction,
  input wire logic read_mask_instruction,
  input wire logic [7:0] acc_in,
  output logic [7:0] status_word_ff,
  output logic status_valid_ff,
  // Core interrupt state
  input wire logic global_interrupt_enable_flag,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_request_ff,
  // Vectored request pins
  input wire logic vectored_irq_top,
  input wire logic vectored_irq_middle,
  input wire logic vectored_irq_bottom,
  // Multiplexed address/data bus
  input wire cims_pkg::cims_tstate_type t_state,
  input wire logic [AD_WIDTH-1:0] ad_in,
  output logic [AD_WIDTH-1:0] ad_out_ff,
  output logic ad_oe_ff
);
  import cims_pkg::*;

  // Refuse a bus width the hold path cannot serve
  if (AD_WIDTH < 1) begin : g_bad_width
    $error("AD_WIDTH must be at least one");
  end

  logic [2:0] irq_pins;
  logic [2:0] pend;
  logic clear_top;
  logic [2:0] mask_ff;
  logic [2:0] nxt_mask;
  logic [7:0] nxt_status;
  logic nxt_status_valid;
  logic [2:0] nxt_request;
  logic [AD_WIDTH-1:0] ad_hold_ff;
  logic [AD_WIDTH-1:0] nxt_ad_hold;
  logic [AD_WIDTH-1:0] nxt_ad_out;
  logic nxt_ad_oe;
  logic late_state;

  assign irq_pins = {vectored_irq_top, vectored_irq_middle, vectored_irq_bottom};

  // R2 top latch clear
  // Clear on control bit 4 or on acknowledge of the top input
  assign clear_top = (set_mask_instruction & acc_in[CTRL_CLR_TOP_BIT]) | irq_ack[IRQ_TOP];

  // R13 pending kept
  // Pending cells: edge latch for top, level for the others
  for (genvar i = 0; i < IRQ_COUNT; i++) begin : g_cell
    cims_irq_cell #(
      .EDGE_MODE(i == IRQ_TOP)
    ) u_cell (
      .sys_clk(sys_clk),
      .rst(rst),
      .irq_level(irq_pins[i]),
      .clear_req((i == IRQ_TOP) ? clear_top : 1'b0),
      .pending(pend[i])
    );
  end

  // Mask next value
  always_comb begin
    nxt_mask = mask_ff;
    // R1 accumulator capture
    // R3 update enable gate
    // R12 upper bits ignored
    if (set_mask_instruction && acc_in[CTRL_MSE_BIT]) begin
      // R4 top mask
      nxt_mask[IRQ_TOP] = acc_in[CTRL_MASK_TOP_BIT];
      // R5 middle mask
      nxt_mask[IRQ_MID] = acc_in[CTRL_MASK_MID_BIT];
      // R6 bottom mask
      nxt_mask[IRQ_BOT] = acc_in[CTRL_MASK_BOT_BIT];
    end
  end

  // Mask register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // Status word and service request next values
  always_comb begin
    nxt_status = status_word_ff;
    nxt_status_valid = read_mask_instruction;
    // R7 status load
    if (read_mask_instruction) begin
      nxt_status = 8'h00;
      // R8 pending bits
      nxt_status[STAT_PEND_TOP_BIT] = pend[IRQ_TOP];
      nxt_status[STAT_PEND_MID_BIT] = pend[IRQ_MID];
      nxt_status[STAT_PEND_BOT_BIT] = pend[IRQ_BOT];
      // R9 enable bit
      nxt_status[STAT_GIE_BIT] = global_interrupt_enable_flag;
      // R10 mask bits
      nxt_status[STAT_MASK_TOP_BIT] = mask_ff[IRQ_TOP];
      nxt_status[STAT_MASK_MID_BIT] = mask_ff[IRQ_MID];
      nxt_status[STAT_MASK_BOT_BIT] = mask_ff[IRQ_BOT];
    end
    // R13 service gate
    // Highest unmasked pending input wins, only when globally enabled
    nxt_request = 3'h0;
    if (global_interrupt_enable_flag) begin
      if (pend[IRQ_TOP] && !mask_ff[IRQ_TOP]) begin
        nxt_request[IRQ_TOP] = 1'b1;
      end else if (pend[IRQ_MID] && !mask_ff[IRQ_MID]) begin
        nxt_request[IRQ_MID] = 1'b1;
      end else if (pend[IRQ_BOT] && !mask_ff[IRQ_BOT]) begin
        nxt_request[IRQ_BOT] = 1'b1;
      end
    end
  end

  // Status and request registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_word_ff <= STATUS_RST;
      status_valid_ff <= 1'b0;
      irq_request_ff <= REQUEST_RST;
    end else begin
      status_word_ff <= nxt_status;
      status_valid_ff <= nxt_status_valid;
      irq_request_ff <= nxt_request;
    end
  end

  // Late states of a machine cycle
  assign late_state = (t_state == CIMS_T4) || (t_state == CIMS_T5) || (t_state == CIMS_T6);

  // Bus hold next values
  always_comb begin
    nxt_ad_hold = ad_hold_ff;
    nxt_ad_out = ad_in;
    nxt_ad_oe = 1'b0;
    // R11 bus retention
    // Capture in T3, replay through T4..T6 to keep the bus quiet
    if (t_state == CIMS_T3) begin
      nxt_ad_hold = ad_in;
    end
    if (late_state) begin
      nxt_ad_out = ad_hold_ff;
      nxt_ad_oe = 1'b1;
    end
  end

  // Bus hold registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ad_hold_ff <= '0;
      ad_out_ff <= '0;
      ad_oe_ff <= 1'b0;
    end else begin
      ad_hold_ff <= nxt_ad_hold;
      ad_out_ff <= nxt_ad_out;
      ad_oe_ff <= nxt_ad_oe;
    end
  end

  // Checks on masks, latch, status, service and bus
  // Masks follow the control word when enabled
  chk_mask_top_load: assert property (@(posedge sys_clk) disable iff (rst) // R4
    (set_mask_instruction && acc_in[CTRL_MSE_BIT]) |=>
      (mask_ff[IRQ_TOP] == $past(acc_in[CTRL_MASK_TOP_BIT])))
    else $error("top mask not loaded");
  chk_mask_mid_load: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (set_mask_instruction && acc_in[CTRL_MSE_BIT]) |=>
      (mask_ff[IRQ_MID] == $past(acc_in[CTRL_MASK_MID_BIT])))
    else $error("middle mask not loaded");
  chk_mask_bot_load: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (set_mask_instruction && acc_in[CTRL_MSE_BIT]) |=>
      (mask_ff[IRQ_BOT] == $past(acc_in[CTRL_MASK_BOT_BIT])))
    else $error("bottom mask not loaded");
  chk_mask_no_update: assert property (@(posedge sys_clk) disable iff (rst) // R3
    !(set_mask_instruction && acc_in[CTRL_MSE_BIT]) |=> $stable(mask_ff))
    else $error("mask changed without update enable");

  // A set-mask word without the update enable keeps every mask
  chk_mask_keep_off: assert property (@(posedge sys_clk) disable iff (rst) // R12
    (set_mask_instruction && !acc_in[CTRL_MSE_BIT]) |=> $stable(mask_ff))
    else $error("mask changed by a word without update enable");

  // Top latch cleared unless a new edge arrives
  chk_top_latch_clear: assert property (@(posedge sys_clk) disable iff (rst) // R2
    (set_mask_instruction && acc_in[CTRL_CLR_TOP_BIT] && !$rose(vectored_irq_top))
      |=> !pend[IRQ_TOP])
    else $error("top latch not cleared");
  chk_top_edge_wins: assert property (@(posedge sys_clk) disable iff (rst) // R13
    $rose(vectored_irq_top) |=> pend[IRQ_TOP])
    else $error("top edge lost");

  // Acknowledge of the top input also empties its latch
  chk_top_ack_clear: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (irq_ack[IRQ_TOP] && !$rose(vectored_irq_top)) |=> !pend[IRQ_TOP])
    else $error("top latch not cleared by acknowledge");

  // Latch keeps its request until cleared, masked or not
  chk_top_latch_keep: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (pend[IRQ_TOP] && !clear_top) |=> pend[IRQ_TOP])
    else $error("top pending lost without clear");

  // Level inputs pend one cycle after their pins
  chk_level_pending: assert property (@(posedge sys_clk) disable iff (rst) // R8
    1'b1 |=> (pend[IRQ_MID:IRQ_BOT] ==
      $past({vectored_irq_middle, vectored_irq_bottom})))
    else $error("level pending does not follow pins");

  // Status word contents one cycle after the read strobe
  chk_status_pending: assert property (@(posedge sys_clk) disable iff (rst) // R8
    read_mask_instruction |=> status_valid_ff &&
      (status_word_ff[STAT_PEND_TOP_BIT:STAT_PEND_BOT_BIT] == $past(pend)))
    else $error("status pending bits wrong");
  chk_status_enable: assert property (@(posedge sys_clk) disable iff (rst) // R9
    read_mask_instruction |=> (status_word_ff[STAT_GIE_BIT] ==
      $past(global_interrupt_enable_flag)))
    else $error("status enable bit wrong");
  chk_status_masks: assert property (@(posedge sys_clk) disable iff (rst) // R10
    read_mask_instruction |=> (status_word_ff[STAT_MASK_TOP_BIT:STAT_MASK_BOT_BIT] ==
      $past(mask_ff)) && !status_word_ff[7])
    else $error("status mask bits wrong");

  // Valid pulses only after a read; the word stands until the next one
  chk_status_valid_pulse: assert property (@(posedge sys_clk) disable iff (rst) // R7
    !read_mask_instruction |=> !status_valid_ff)
    else $error("status valid without read");
  chk_status_stands: assert property (@(posedge sys_clk) disable iff (rst) // R7
    !read_mask_instruction |=> $stable(status_word_ff))
    else $error("status word changed without read");

  // No service for masked inputs or while disabled
  chk_masked_no_service: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (mask_ff[IRQ_TOP] || !global_interrupt_enable_flag) |=> !irq_request_ff[IRQ_TOP])
    else $error("masked top input serviced");
  chk_mid_no_service: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (mask_ff[IRQ_MID] || !global_interrupt_enable_flag) |=> !irq_request_ff[IRQ_MID])
    else $error("masked middle input serviced");
  chk_bot_no_service: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (mask_ff[IRQ_BOT] || !global_interrupt_enable_flag) |=> !irq_request_ff[IRQ_BOT])
    else $error("masked bottom input serviced");

  // One request at a time, and an enabled pending top input wins
  chk_request_onehot: assert property (@(posedge sys_clk) disable iff (rst) // R13
    $onehot0(irq_request_ff))
    else $error("more than one service request");
  chk_request_top_first: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (global_interrupt_enable_flag && pend[IRQ_TOP] && !mask_ff[IRQ_TOP]) |=>
      (irq_request_ff == 3'h4))
    else $error("top input not served first");

  // Unmasked pending level inputs are served when nothing above is
  chk_request_middle: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (global_interrupt_enable_flag && pend[IRQ_MID] && !mask_ff[IRQ_MID] &&
      (mask_ff[IRQ_TOP] || !pend[IRQ_TOP])) |=> irq_request_ff[IRQ_MID])
    else $error("middle input not served");
  chk_request_bottom: assert property (@(posedge sys_clk) disable iff (rst) // R13
    (global_interrupt_enable_flag && pend[IRQ_BOT] && !mask_ff[IRQ_BOT] &&
      (mask_ff[IRQ_TOP] || !pend[IRQ_TOP]) && (mask_ff[IRQ_MID] || !pend[IRQ_MID]))
      |=> irq_request_ff[IRQ_BOT])
    else $error("bottom input not served");

  // Bus carries the T3 value through the late states
  chk_bus_hold: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (t_state == CIMS_T3) ##1 (t_state == CIMS_T4) |=> ad_oe_ff &&
      (ad_out_ff == $past(ad_in, 2)))
    else $error("bus not held in T4");
  chk_bus_hold_t5: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (t_state == CIMS_T3) ##1 (t_state == CIMS_T4) ##1 (t_state == CIMS_T5) |=>
      ad_oe_ff && (ad_out_ff == $past(ad_in, 3)))
    else $error("bus not held in T5");
  chk_bus_hold_t6: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (t_state == CIMS_T3) ##1 (t_state == CIMS_T4) ##1 (t_state == CIMS_T5) ##1
      (t_state == CIMS_T6) |=> ad_oe_ff && (ad_out_ff == $past(ad_in, 4)))
    else $error("bus not held in T6");

  // Output enable marks exactly the cycles after a late state
  chk_bus_oe_late: assert property (@(posedge sys_clk) disable iff (rst) // R11
    1'b1 |=> (ad_oe_ff == $past(late_state)))
    else $error("bus enable outside the held phase");

endmodule : cims_mask_status
`default_nettype wire

// ### dv/cims_bus_model.sv
// Core-side model that runs machine cycles on the multiplexed bus.
// Assumes the bench raises run after reset; outside a run t_state idles and ad_in inverts each cycle.
`timescale 1ns/1ps
`default_nettype none
module cims_bus_model (
  // Clock and run control
  input wire logic sys_clk,
  input wire logic run,
  // Bus cycle outputs
  output var cims_pkg::cims_tstate_type t_state,
  output var logic [7:0] ad_in
);
  import cims_pkg::*;
  logic [7:0] pat;
  // Idle start values
  initial begin
    t_state = CIMS_TIDLE;
    ad_in = 8'h00;
    pat = 8'h3c;
  end
  // Steps T1..T6 with a fresh byte each cycle so a held bus shows
  always @(negedge sys_clk) begin
    pat = pat + 8'h1d;
    ad_in = run ? pat : ~ad_in;
    if (!run) begin
      t_state = CIMS_TIDLE;
    end else if (t_state == CIMS_T6 || t_state == CIMS_TIDLE) begin
      t_state = CIMS_T1;
    end else begin
      t_state = cims_tstate_type'(t_state + 3'h1);
    end
  end
endmodule : cims_bus_model
`default_nettype wire

// ### dv/cims_mask_status_bench.sv
// Self-checking bench for the interrupt mask and status block.
// Assumes a 25 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module cims_mask_status_bench;
  import cims_pkg::*;
  logic sys_clk, rst, set_mi, read_mi, gie, top, mid, bot, bus_run, valid, oe, exp_oe;
  logic [7:0] acc_in, status, ad_in, ad_out, exp_ad, t3_val;
  logic [2:0] irq_ack, req;
  cims_tstate_type t_state;
  int failures, comparisons, cycles;

  // Design and bus partner
  cims_mask_status u_cims_mask_status (.sys_clk(sys_clk), .rst(rst),
    .set_mask_instruction(set_mi), .read_mask_instruction(read_mi), .acc_in(acc_in),
    .status_word_ff(status), .status_valid_ff(valid), .global_interrupt_enable_flag(gie),
    .irq_ack(irq_ack), .irq_request_ff(req), .vectored_irq_top(top),
    .vectored_irq_middle(mid), .vectored_irq_bottom(bot), .t_state(t_state),
    .ad_in(ad_in), .ad_out_ff(ad_out), .ad_oe_ff(oe));
  cims_bus_model u_cims_bus_model (.sys_clk(sys_clk), .run(bus_run), .t_state(t_state),
    .ad_in(ad_in));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Expected bus value and timeout counter
  always @(posedge sys_clk) begin
    if (t_state == CIMS_T3) begin
      t3_val <= ad_in;
    end
    exp_oe <= t_state inside {CIMS_T4, CIMS_T5, CIMS_T6};
    exp_ad <= (t_state inside {CIMS_T4, CIMS_T5, CIMS_T6}) ? t3_val : ad_in;
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic set_mask(input logic [7:0] word);
    @(negedge sys_clk);
    set_mi = 1'b1;
    acc_in = word;
    @(negedge sys_clk);
    set_mi = 1'b0;
  endtask : set_mask

  // Read status, then check the one-cycle answer and the request lines
  task automatic read_mask(input logic [7:0] exp, input logic [2:0] exp_req);
    @(negedge sys_clk);
    read_mi = 1'b1;
    @(negedge sys_clk);
    read_mi = 1'b0;
    check({7'h00, valid}, 8'h01);
    check(status, exp);
    check({5'h00, req}, {5'h00, exp_req});
  endtask : read_mask

  task automatic pulse_top();
    @(negedge sys_clk);
    top = 1'b1;
    @(negedge sys_clk);
    top = 1'b0;
  endtask : pulse_top

  task automatic conclude();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    {rst, set_mi, read_mi, gie, top, mid, bot, bus_run} = 8'h80;
    acc_in = 8'h00;
    irq_ack = 3'h0;
    {failures, comparisons, cycles} = '0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    read_mask(8'h07, 3'h0);
    gie = 1'b1;
    read_mask(8'h0f, 3'h0);
    for (int m = 0; m < 8; m++) begin
      set_mask(8'h08 | 8'(m));
      read_mask(8'h08 | 8'(m), 3'h0);
    end
    set_mask(8'hea);
    read_mask(8'h0a, 3'h0);
    set_mask(8'h05);
    read_mask(8'h0a, 3'h0);
    mid = 1'b1;
    bot = 1'b1;
    set_mask(8'h08);
    read_mask(8'h38, 3'h2);
    pulse_top();
    read_mask(8'h78, 3'h4);
    set_mask(8'h10);
    read_mask(8'h38, 3'h2);
    {mid, bot} = 2'b00;
    pulse_top();
    irq_ack = 3'h4;
    @(negedge sys_clk);
    irq_ack = 3'h0;
    read_mask(8'h08, 3'h0);
    set_mask(8'h0c);
    pulse_top();
    read_mask(8'h4c, 3'h0);
    set_mask(8'h08);
    read_mask(8'h48, 3'h4);
    gie = 1'b0;
    read_mask(8'h40, 3'h0);
    set_mask(8'h10);
    read_mask(8'h00, 3'h0);
    {gie, bot} = 2'h3;
    set_mask(8'h0a);
    read_mask(8'h1a, 3'h1);
    bus_run <= 1'b1;
    repeat (30) begin
      @(negedge sys_clk);
      check(ad_out, exp_ad);
      check({7'h00, oe}, {7'h00, exp_oe});
    end
    conclude();
  end
endmodule : cims_mask_status_bench
`default_nettype wire
